// File: hw/ssa_ctrl_pkg.sv
/*
 Constants for the synchronous serial adapter control block.
 Assumes a single clock domain and a host-driven parallel register port.
*/
`default_nettype none
package ssa_ctrl_pkg;
    localparam int          DATA_W        = 8;
    localparam int          BIT_RX_RESET  = 0;
    localparam int          BIT_TX_RESET  = 1;
    localparam int          BIT_STRIP     = 2;
    localparam int          BIT_CLR_SYNC  = 3;
    localparam int          BIT_TX_IE     = 4;
    localparam int          BIT_RX_IE     = 5;
    localparam int          BIT_AC_LOW    = 6;
    localparam int          BIT_AC_HIGH   = 7;
    localparam logic [7:0]  PRIMARY_RESET = 8'h03;
    localparam logic [1:0]  AC_SECONDARY  = 2'h0;
    localparam logic [1:0]  AC_TERTIARY   = 2'h1;
    localparam logic [1:0]  AC_SYNC_CODE  = 2'h2;
    localparam logic [1:0]  AC_TX_FIFO    = 2'h3;
    localparam int          TERTIARY_W    = 4;
    localparam int          BIT_TWO_SYNC  = 1;
    localparam logic [7:0]  ALL_ONES      = 8'hff;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [3:0]  ZERO_NIBBLE   = 4'h0;
endpackage : ssa_ctrl_pkg
`default_nettype wire

// File: hw/sync_serial_adapter_control.sv
/*
 Control register, write decode, receive/transmit section resets, sync strip,
 interrupt request and a two-entry transmit buffer.
 Assumes synchronous inputs on clk; bus write strobe busWrite qualifies registerSelect/readWrite.
*/
// Notes on behaviour
// - Primary control written when select is zero
// - Receive reset clears receiver logic and flags
// - Receive reset forces shift register to ones
// - Transmit reset clears transmitter logic and flags
// - Transmit buffer accepts writes one clock later
// - Transmit reset inhibits available flag in sync modes
// - Strip-sync discards characters matching sync code
// - Synchronising characters never reach receive buffer
// - Clear-sync drops and blocks receiver synchronisation
// - Transmit enable and available drive interrupt
// - Receive enable and data available drive interrupt
// - Address bits choose the select-one write target
// - Secondary control written at address bits 00
// - Tertiary control written at address bits 01
// - Select picks primary or select-one target, read/write high blocks the write
`default_nettype none
module sync_serial_adapter_control
    import ssa_ctrl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              resetInputN,
    input  wire logic              busWrite,
    input  wire logic              registerSelect,
    input  wire logic              readWrite,
    input  wire logic [DATA_W-1:0] busData,
    input  wire logic              rxCharValid,
    input  wire logic [DATA_W-1:0] rxChar,
    input  wire logic              rxSyncChar,
    input  wire logic              rxFifoReady,
    input  wire logic              txShiftReady,
    output logic                   txWordValid,
    output logic [DATA_W-1:0]      txWord,
    output logic                   rxFifoValid,
    output logic [DATA_W-1:0]      rxFifoData,
    output logic                   rxInSync,
    output logic [DATA_W-1:0]      rxShiftOut,
    output logic                   transmitRegAvailable,
    output logic                   irqStatus,
    output logic                   irqOutN,
    output logic [DATA_W-1:0]      secondaryControl,
    output logic [TERTIARY_W-1:0]  tertiaryControl,
    output logic [DATA_W-1:0]      syncCode
);
    ////////////////////////////////////////////////////////////////////////////
    // Register write decode
    logic [DATA_W-1:0]     primary_reg, primary_next;
    logic [DATA_W-1:0]     secondary_reg, secondary_next;
    logic [TERTIARY_W-1:0] tertiary_reg, tertiary_next;
    logic [DATA_W-1:0]     sync_reg, sync_next;
    logic                  wrPrimary, wrSelOne, wrTxFifo, hwReset;
    logic [1:0]            addrCtrl;
    logic                  rxReset, txReset, txResetDly_reg;

    assign hwReset  = sys_rst || !resetInputN;
    assign addrCtrl = {primary_reg[BIT_AC_HIGH], primary_reg[BIT_AC_LOW]};
    assign wrPrimary = busWrite && !registerSelect && !readWrite;
    assign wrSelOne  = busWrite && registerSelect && !readWrite;
    assign wrTxFifo  = wrSelOne && (addrCtrl == AC_TX_FIFO);
    assign rxReset = primary_reg[BIT_RX_RESET];
    assign txReset = primary_reg[BIT_TX_RESET];

    always_comb begin
        primary_next   = primary_reg;
        secondary_next = secondary_reg;
        tertiary_next  = tertiary_reg;
        sync_next      = sync_reg;
        if (wrPrimary) begin
            primary_next = busData;
        end
        if (wrSelOne) begin
            unique case (addrCtrl)
                AC_SECONDARY: secondary_next = busData;
                AC_TERTIARY:  tertiary_next  = busData[TERTIARY_W-1:0];
                AC_SYNC_CODE: sync_next      = busData;
                AC_TX_FIFO:   sync_next      = sync_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (hwReset) begin
            primary_reg    <= PRIMARY_RESET;
            secondary_reg  <= ZERO_BYTE;
            tertiary_reg   <= ZERO_NIBBLE;
            sync_reg       <= ZERO_BYTE;
            txResetDly_reg <= 1'b1;
        end else begin
            primary_reg    <= primary_next;
            secondary_reg  <= secondary_next;
            tertiary_reg   <= tertiary_next;
            sync_reg       <= sync_next;
            txResetDly_reg <= txReset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer, two entries
    logic [DATA_W-1:0] txMem_reg [2];
    logic [DATA_W-1:0] txMem_next [2];
    logic [1:0]        txCount_reg, txCount_next;
    logic              txHead_reg, txHead_next;
    logic              txAccept, txPop, txAvail_next;

    assign txAccept = wrTxFifo && !txReset && !txResetDly_reg && (txCount_reg != 2'h2);
    assign txPop    = (txCount_reg != 2'h0) && txShiftReady && !txReset;

    always_comb begin
        txMem_next   = txMem_reg;
        txHead_next  = txHead_reg;
        txCount_next = txCount_reg;
        if (txReset) begin
            txHead_next  = 1'b0;
            txCount_next = 2'h0;
        end else begin
            if (txAccept) begin
                txMem_next[txHead_reg ^ txCount_reg[0]] = busData;
            end
            if (txPop) begin
                txHead_next = !txHead_reg;
            end
            txCount_next = 2'(txCount_reg + {1'b0, txAccept} - {1'b0, txPop});
        end
        txAvail_next = (txCount_next != 2'h2) && !txReset;
    end

    always_ff @(posedge clk) begin
        if (hwReset) begin
            txMem_reg[0] <= ZERO_BYTE;
            txMem_reg[1] <= ZERO_BYTE;
            txHead_reg   <= 1'b0;
            txCount_reg  <= 2'h0;
            transmitRegAvailable <= 1'b0;
        end else begin
            txMem_reg    <= txMem_next;
            txHead_reg   <= txHead_next;
            txCount_reg  <= txCount_next;
            transmitRegAvailable <= txAvail_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver sync, strip and delivery
    logic              inSync_next, rxValid_next, stripIt;
    logic [DATA_W-1:0] rxData_next, rxShift_next;

    assign stripIt = rxSyncChar
                     || (primary_reg[BIT_STRIP] && rxChar == sync_reg);

    always_comb begin
        inSync_next  = rxInSync;
        rxValid_next = rxFifoValid;
        rxData_next  = rxFifoData;
        rxShift_next = rxChar;
        if (rxReset) begin
            inSync_next  = 1'b0;
            rxValid_next = 1'b0;
            rxShift_next = ALL_ONES;
        end else begin
            if (primary_reg[BIT_CLR_SYNC]) begin
                inSync_next = 1'b0;
            end else if (rxCharValid && rxSyncChar) begin
                inSync_next = 1'b1;
            end
            if (rxFifoValid && rxFifoReady) begin
                rxValid_next = 1'b0;
            end
            if (rxCharValid && inSync_next && rxInSync && !stripIt
                && (!rxFifoValid || rxFifoReady)) begin
                rxValid_next = 1'b1;
                rxData_next  = rxChar;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (hwReset) begin
            rxInSync    <= 1'b0;
            rxFifoValid <= 1'b0;
            rxFifoData  <= ZERO_BYTE;
            rxShiftOut  <= ALL_ONES;
        end else begin
            rxInSync    <= inSync_next;
            rxFifoValid <= rxValid_next;
            rxFifoData  <= rxData_next;
            rxShiftOut  <= rxShift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request and registered outputs
    logic irq_next;
    assign irq_next = (primary_next[BIT_TX_IE] && txAvail_next)
                      || (primary_next[BIT_RX_IE] && rxValid_next);

    always_ff @(posedge clk) begin
        if (hwReset) begin
            irqStatus        <= 1'b0;
            irqOutN          <= 1'b1;
            txWordValid      <= 1'b0;
            txWord           <= ZERO_BYTE;
            secondaryControl <= ZERO_BYTE;
            tertiaryControl  <= ZERO_NIBBLE;
            syncCode         <= ZERO_BYTE;
        end else begin
            irqStatus        <= irq_next;
            irqOutN          <= !irq_next;
            txWordValid      <= (txCount_next != 2'h0);
            txWord           <= txMem_next[txHead_next];
            secondaryControl <= secondary_next;
            tertiaryControl  <= tertiary_next;
            syncCode         <= sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rxResetOn;
        rxReset;
    endsequence
    property p_rxShiftOnes;
        @(posedge clk) disable iff (hwReset) s_rxResetOn |=> rxShiftOut == ALL_ONES;
    endproperty
    a_rxShiftOnes: assert property (p_rxShiftOnes) else $error("shift not ones");
    property p_rxClear;
        @(posedge clk) disable iff (hwReset) rxReset |=> !rxFifoValid && !rxInSync;
    endproperty
    a_rxClear: assert property (p_rxClear) else $error("receiver not cleared");
    property p_txClear;
        @(posedge clk) disable iff (hwReset) txReset |=> txCount_reg == 2'h0 && !txWordValid;
    endproperty
    a_txClear: assert property (p_txClear) else $error("transmitter not cleared");
    property p_txAvailInhibit;
        @(posedge clk) disable iff (hwReset)
            txReset |=> !transmitRegAvailable;
    endproperty
    a_txAvailInhibit: assert property (p_txAvailInhibit) else $error("available flag");
    property p_txAcceptDelay;
        @(posedge clk) disable iff (hwReset) $fell(txReset) |-> !txAccept;
    endproperty
    a_txAcceptDelay: assert property (p_txAcceptDelay) else $error("early accept");
    property p_strip;
        @(posedge clk) disable iff (hwReset)
            rxCharValid && stripIt && !rxFifoValid |=> !rxFifoValid;
    endproperty
    a_strip: assert property (p_strip) else $error("stripped char delivered");
    property p_clrSync;
        @(posedge clk) disable iff (hwReset) primary_reg[BIT_CLR_SYNC] |=> !rxInSync;
    endproperty
    a_clrSync: assert property (p_clrSync) else $error("sync not dropped");
    property p_irqPair;
        @(posedge clk) disable iff (hwReset) irqOutN == !irqStatus;
    endproperty
    a_irqPair: assert property (p_irqPair) else $error("irq mismatch");
    property p_rxIrq;
        @(posedge clk) disable iff (hwReset)
            primary_reg[BIT_RX_IE] && rxFifoValid |-> irqStatus;
    endproperty
    a_rxIrq: assert property (p_rxIrq) else $error("rx irq missing");
    property p_txIrq;
        @(posedge clk) disable iff (hwReset)
            primary_reg[BIT_TX_IE] && transmitRegAvailable |-> irqStatus;
    endproperty
    a_txIrq: assert property (p_txIrq) else $error("tx irq missing");
    property p_secWrite;
        @(posedge clk) disable iff (hwReset)
            wrSelOne && addrCtrl == AC_SECONDARY |=> secondaryControl == $past(busData);
    endproperty
    a_secWrite: assert property (p_secWrite) else $error("secondary write");
endmodule : sync_serial_adapter_control
`default_nettype wire

// File: test/far_side_model.sv
/*
 Far-side model: transmit shifter taking buffer words and receive sink taking delivered chars.
 Assumes the block's clk and sys_rst; the bench sets the stall levels.
*/
`default_nettype none
module far_side_model
    import ssa_ctrl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              txStall,
    input  wire logic              rxStall,
    input  wire logic              txWordValid,
    input  wire logic [DATA_W-1:0] txWord,
    input  wire logic              rxFifoValid,
    input  wire logic [DATA_W-1:0] rxFifoData,
    output logic                   txShiftReady,
    output logic                   rxFifoReady,
    output logic [DATA_W-1:0]      lastTx,
    output logic [DATA_W-1:0]      lastRx,
    output int                     txCount,
    output int                     rxCount
);
    timeunit 1ns;
    timeprecision 1ns;
    assign txShiftReady = !txStall;
    assign rxFifoReady  = !rxStall;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txCount <= 0;
            rxCount <= 0;
            lastTx  <= 8'h00;
            lastRx  <= 8'h00;
        end else begin
            if (txWordValid && txShiftReady) begin
                txCount <= txCount + 1;
                lastTx  <= txWord;
            end
            if (rxFifoValid && rxFifoReady) begin
                rxCount <= rxCount + 1;
                lastRx  <= rxFifoData;
            end
        end
    end
endmodule : far_side_model
`default_nettype wire

// File: test/sync_serial_adapter_control_bench.sv
/*
 Self-checking bench for the adapter control block.
 Assumes the far-side model and a 25 MHz clock.
*/
`default_nettype none
module sync_serial_adapter_control_bench;
    import ssa_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, resetInputN = 1, busWrite = 0, registerSelect = 0, readWrite = 0;
    logic rxCharValid = 0, rxSyncChar = 0, txStall = 0, rxStall = 0;
    logic [7:0] busData = 8'h00, rxChar = 8'h00, ctl = 8'h03;
    logic txShiftReady, rxFifoReady, txWordValid, rxFifoValid, rxInSync, transmitRegAvailable;
    logic irqStatus, irqOutN;
    logic [7:0] txWord, rxFifoData, rxShiftOut, secondaryControl, syncCode, lastTx, lastRx;
    logic [3:0] tertiaryControl;
    int txCount, rxCount, fails = 0, cmpCount = 0, cycles = 0;
    always #20 clk = ~clk;
    sync_serial_adapter_control u_dut (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .resetInputN          (resetInputN),
        .busWrite             (busWrite),
        .registerSelect       (registerSelect),
        .readWrite            (readWrite),
        .busData              (busData),
        .rxCharValid          (rxCharValid),
        .rxChar               (rxChar),
        .rxSyncChar           (rxSyncChar),
        .rxFifoReady          (rxFifoReady),
        .txShiftReady         (txShiftReady),
        .txWordValid          (txWordValid),
        .txWord               (txWord),
        .rxFifoValid          (rxFifoValid),
        .rxFifoData           (rxFifoData),
        .rxInSync             (rxInSync),
        .rxShiftOut           (rxShiftOut),
        .transmitRegAvailable (transmitRegAvailable),
        .irqStatus            (irqStatus),
        .irqOutN              (irqOutN),
        .secondaryControl     (secondaryControl),
        .tertiaryControl      (tertiaryControl),
        .syncCode             (syncCode)
    );
    far_side_model u_far (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .txStall      (txStall),
        .rxStall      (rxStall),
        .txWordValid  (txWordValid),
        .txWord       (txWord),
        .rxFifoValid  (rxFifoValid),
        .rxFifoData   (rxFifoData),
        .txShiftReady (txShiftReady),
        .rxFifoReady  (rxFifoReady),
        .lastTx       (lastTx),
        .lastRx       (lastRx),
        .txCount      (txCount),
        .rxCount      (rxCount)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmpCount++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask : chk
    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic rs, input logic rw, input logic [7:0] d);
        @(posedge clk);
        busWrite <= 1;
        registerSelect <= rs;
        readWrite <= rw;
        busData <= d;
        @(posedge clk);
        busWrite <= 0;
    endtask : wr
    task automatic pri(input logic [7:0] d);
        ctl = d;
        wr(0, 0, d);
    endtask : pri
    task automatic sel(input logic [1:0] ac, input logic [7:0] d);
        pri({ac, ctl[5:0]});
        wr(1, 0, d);
    endtask : sel
    task automatic rxSend(input logic s, input logic [7:0] c);
        @(posedge clk);
        rxCharValid <= 1;
        rxSyncChar <= s;
        rxChar <= c;
        @(posedge clk);
        rxCharValid <= 0;
        repeat (2) settle();
    endtask : rxSend
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        settle();
        chk("txAvail", 8'h00, 8'(transmitRegAvailable));
        chk("rxShift", 8'hff, rxShiftOut);
        rxSend(1, 8'h7e);
        rxSend(0, 8'h42);
        chk("rxCount", 8'h00, 8'(rxCount));
        sel(AC_TX_FIFO, 8'h99);
        settle();
        chk("txValid", 8'h00, 8'(txWordValid));
    endtask : t_reset
    task automatic t_regs;
        pri(8'h00);
        sel(AC_SECONDARY, 8'ha5);
        sel(AC_TERTIARY, 8'h5c);
        sel(AC_SYNC_CODE, 8'h7e);
        wr(1, 1, 8'h00);
        wr(0, 1, 8'hff);
        settle();
        chk("secondary", 8'ha5, secondaryControl);
        chk("tertiary", 8'h0c, 8'(tertiaryControl));
        chk("syncRead", 8'h7e, syncCode);
        chk("txAvailRd", 8'h01, 8'(transmitRegAvailable));
    endtask : t_regs
    task automatic t_tx;
        txStall <= 1;
        pri(8'h02);
        pri(8'hc0);
        wr(1, 0, 8'h11);
        wr(1, 0, 8'h22);
        wr(1, 0, 8'h33);
        settle();
        chk("txHead", 8'h11, txWord);
        chk("txFull", 8'h00, 8'(transmitRegAvailable));
        txStall <= 0;
        for (int i = 0; i < 20 && txCount != 2; i++) settle();
        repeat (3) settle();
        chk("txCount", 8'h02, 8'(txCount));
        chk("txLast", 8'h22, lastTx);
        txStall <= 1;
        wr(1, 0, 8'h44);
        pri(8'hc2);
        settle();
        chk("txFlush", 8'h00, 8'(txWordValid));
        chk("txInhib", 8'h00, 8'(transmitRegAvailable));
        ctl = 8'hc0;
        @(posedge clk);
        busWrite <= 1;
        registerSelect <= 0;
        readWrite <= 0;
        busData <= 8'hc0;
        @(posedge clk);
        registerSelect <= 1;
        busData <= 8'h55;
        @(posedge clk);
        busWrite <= 0;
        settle();
        chk("txLockout", 8'h00, 8'(txWordValid));
        wr(1, 0, 8'h66);
        settle();
        chk("txReload", 8'h66, txWord);
        txStall <= 0;
        pri(8'h00);
    endtask : t_tx
    task automatic t_rx;
        rxSend(1, 8'h7e);
        rxSend(0, 8'h55);
        chk("rxSync", 8'h01, 8'(rxCount));
        chk("rxFirst", 8'h55, lastRx);
        pri(8'h04);
        rxSend(0, 8'h7e);
        rxSend(0, 8'h66);
        chk("rxStrip", 8'h02, 8'(rxCount));
        chk("rxLast", 8'h66, lastRx);
        pri(8'h08);
        rxSend(1, 8'h7e);
        rxSend(0, 8'h77);
        chk("inSync", 8'h00, 8'(rxInSync));
        chk("rxBlock", 8'h02, 8'(rxCount));
        pri(8'h00);
        rxSend(1, 8'h7e);
        rxSend(0, 8'h88);
        chk("rxResync", 8'h03, 8'(rxCount));
    endtask : t_rx
    task automatic t_irq;
        pri(8'h10);
        settle();
        chk("irqTx", 8'h00, 8'(irqOutN));
        chk("irqStat", 8'h01, 8'(irqStatus));
        pri(8'h00);
        rxStall <= 1;
        rxSend(0, 8'h99);
        chk("irqOff", 8'h01, 8'(irqOutN));
        pri(8'h20);
        settle();
        chk("irqRx", 8'h00, 8'(irqOutN));
        pri(8'h01);
        settle();
        chk("rxDrop", 8'h00, 8'(rxFifoValid));
        chk("rxOnes", 8'hff, rxShiftOut);
        rxStall <= 0;
    endtask : t_irq
    task automatic t_hw;
        pri(8'h00);
        @(posedge clk);
        resetInputN <= 0;
        @(posedge clk);
        resetInputN <= 1;
        settle();
        chk("hwTx", 8'h00, 8'(transmitRegAvailable));
        chk("hwRx", 8'hff, rxShiftOut);
    endtask : t_hw
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 0;
        t_reset();
        t_regs();
        t_tx();
        t_rx();
        t_irq();
        t_hw();
        give_verdict();
    end
endmodule : sync_serial_adapter_control_bench
`default_nettype wire
